// *** rtl/tmc_pkg.sv ***
// package: constants and types of the temperature monitor control
package tmc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] REG_LTEMP = 8'h00;
   localparam logic [7:0] REG_RTEMP = 8'h01;
   localparam logic [7:0] REG_STAT = 8'h02;
   localparam logic [7:0] REG_CFG = 8'h03;
   localparam logic [7:0] REG_LHI = 8'h05;
   localparam logic [7:0] REG_LLO = 8'h06;
   localparam logic [7:0] REG_RHI = 8'h07;
   localparam logic [7:0] REG_RLO = 8'h08;
   localparam logic [7:0] REG_REV = 8'hfe;

   // field positions
   localparam int CFG_MASK_BIT = 7;
   localparam int CFG_STBY_BIT = 6;
   localparam logic [7:0] CFG_WMASK = 8'hc0;
   localparam int ST_LHI = 6;
   localparam int ST_LLO = 5;
   localparam int ST_RHI = 4;
   localparam int ST_RLO = 3;
   localparam int ST_OPEN = 2;
   localparam logic [7:0] STAT_FLAGS = 8'h7c;

   // values after reset
   localparam logic [7:0] TEMP_RST = 8'h80;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] LIM_HI_RST = 8'h7f;
   localparam logic [7:0] LIM_LO_RST = 8'h00;
   localparam logic [7:0] RDATA_NONE = 8'h00;

   // identity nibbles: values are arbitrary
   localparam logic [3:0] REV_PART = 4'h5;
   localparam logic [3:0] REV_STEP = 4'h1;

   // counts
   localparam int AVG_CNT = 16;
   localparam logic [3:0] AVG_LAST = 4'(AVG_CNT - 1);
   localparam logic [1:0] STRAP_WAIT = 2'h2;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [3:0] BITS_ACKED = 4'h9;

   ////////////////////////////////////////////////////////////////////////
   // three-level strap and address table
   typedef logic [1:0] tmc_strap_t;
   localparam tmc_strap_t STRAP_LOW = 2'h0;
   localparam tmc_strap_t STRAP_FLOAT = 2'h1;
   localparam logic [3:0] ADDR_HI_LOW = 4'h3;
   localparam logic [3:0] ADDR_HI_FLOAT = 4'h5;
   localparam logic [3:0] ADDR_HI_HIGH = 4'h9;
   localparam logic [2:0] ADDR_LO_FLOAT = 3'h1;
   localparam logic [2:0] ADDR_LO_HIGH = 3'h4;

   function automatic logic [6:0] tmc_addr(input tmc_strap_t a0,
                                           input tmc_strap_t a1);
      logic [2:0] lo;
      // code 3 on a strap counts as high
      lo = a1[1] ? 3'h2 : {2'h0, a1[0]};
      if (a0 == STRAP_LOW) begin
         return {ADDR_HI_LOW, lo};
      end else if (a0 == STRAP_FLOAT) begin
         return {ADDR_HI_FLOAT, 3'(lo + ADDR_LO_FLOAT)};
      end
      return {ADDR_HI_HIGH, 3'(lo + ADDR_LO_HIGH)};
   endfunction : tmc_addr

   ////////////////////////////////////////////////////////////////////////
   // serial bus states
   typedef enum logic [5:0] {
      BS_IDLE = 6'b00_0001,
      BS_ADDR = 6'b00_0010,
      BS_ACK = 6'b00_0100,
      BS_RX = 6'b00_1000,
      BS_TX = 6'b01_0000,
      BS_MACK = 6'b10_0000
   } tmc_bus_st_t;

   typedef struct packed {
      logic scl_m, scl_s, scl_p;
      logic sd_m, sd_s, sd_p;
      tmc_strap_t a0_m, a0_s, a1_m, a1_s;
      logic op_m, op_s;
      logic [1:0] strap_cnt;
      logic strap_ok;
      logic [6:0] dev_addr;
      tmc_bus_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh, tx, ptr;
      logic rw, first;
      logic [7:0] cfg, lhi, llo, rhi, rlo, ltemp, rtemp, stat;
      logic run, sel, sd_oe, alert_n;
   } tmc_ctl_t;

   localparam tmc_ctl_t CTL_RST = '{
      scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
      sd_m: 1'b1, sd_s: 1'b1, sd_p: 1'b1,
      st: BS_IDLE, cfg: CFG_RST,
      lhi: LIM_HI_RST, rhi: LIM_HI_RST,
      llo: LIM_LO_RST, rlo: LIM_LO_RST,
      ltemp: TEMP_RST, rtemp: TEMP_RST,
      run: 1'b1, alert_n: 1'b1,
      default: '0
   };

   typedef struct packed {
      logic [11:0] sum;
      logic [3:0] cnt;
      logic [7:0] avg;
      logic vld;
   } tmc_avg_t;

   localparam tmc_avg_t AVG_RST = '0;

endpackage : tmc_pkg

// *** rtl/tmc_conv_if.sv ***
// interface: raw samples into the averager and averaged results out
interface tmc_conv_if;
   logic [7:0] raw;
   logic raw_valid;
   logic clear;
   logic [7:0] avg;
   logic avg_valid;
   modport ctl (output raw, output raw_valid, output clear,
                input avg, input avg_valid);
   modport avg_end (input raw, input raw_valid, input clear,
                    output avg, output avg_valid);
endinterface : tmc_conv_if

// *** rtl/tmc_avg.sv ***
// averager: sixteen raw samples of one channel into one clamped result
module tmc_avg (
   input wire logic clock,
   input wire logic rst_n,
   tmc_conv_if.avg_end c
);
   import tmc_pkg::*;

   tmc_avg_t s;
   tmc_avg_t n;
   logic [11:0] tot;

   always_comb begin
      n = s;
      n.vld = 1'b0;
      tot = 12'(s.sum + {{4{c.raw[7]}}, c.raw});
      if (c.clear) begin
         n.sum = '0;
         n.cnt = '0;
      end else if (c.raw_valid) begin
         if (s.cnt == AVG_LAST) begin
            n.vld = 1'b1;
            n.sum = '0;
            n.cnt = '0;
            // negative averages fold to zero: range is 0..127
            n.avg = tot[11] ? 8'h00 : tot[11:4];
         end else begin
            n.sum = tot;
            n.cnt = 4'(s.cnt + 4'h1);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s <= AVG_RST;
      end else begin
         s <= n;
      end
   end

   assign c.avg = s.avg;
   assign c.avg_valid = s.vld;

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [4:0] seen_q;
   always_ff @(posedge clock) begin
      if (!rst_n || c.clear) begin
         seen_q <= '0;
      end else if (s.vld) begin
         // a sample in the result cycle already opens the next average
         seen_q <= 5'(c.raw_valid);
      end else if (c.raw_valid) begin
         seen_q <= 5'(seen_q + 5'h01);
      end
   end

   a_avg_sixteen: assert property (@(posedge clock) disable iff (!rst_n)
      s.vld |-> seen_q == 5'(AVG_CNT))
      else $error("average issued after wrong sample count");
   a_avg_range: assert property (@(posedge clock) disable iff (!rst_n)
      s.vld |-> !s.avg[7])
      else $error("average outside 0..127");

endmodule : tmc_avg

// *** rtl/tmc_ctl.sv ***
// top: conversion sequencing, limits, alarm and serial register access

// Behaviour
// - converter runs free, alternating local and remote channel, no trigger.
// - results stored as 8-bit twos complement in local or remote register.
// - each stored value is the average of sixteen samples of one channel.
// - both temperature registers hold minus 128 until first conversion.
// - converted temperatures are limited to 0 through 127 degrees.
// - unless in standby, conversions start right after reset.
// - pointer resets to 00, the local temperature register; host writes it to read others.
// - upper four revision bits hold a fixed part code.
// - per channel, high flag above high limit, low flag below low limit.
// - status bit 2 set while remote sensor is open.
// - alarm output low whenever any of five flags is set.
// - configuration bit 7 masks the alarm; resets to zero.
// - configuration bit 6 selects standby; bits 5..0 read zero.
// - address straps sampled once after reset, later changes ignored.
// - slave address picked from two three-level straps per table.
module tmc_ctl (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic serial_clock_line,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out_q,
   output logic serial_data_line_oe_q,
   input wire tmc_pkg::tmc_strap_t addr_strap_zero,
   input wire tmc_pkg::tmc_strap_t addr_strap_one,
   input wire logic remote_open,
   input wire logic [7:0] raw_sample,
   input wire logic raw_valid,
   output logic conv_run_q,
   output logic sensor_sel_q,
   output logic alert_n_q
);
   import tmc_pkg::*;

   tmc_ctl_t s;
   tmc_ctl_t n;
   tmc_conv_if c ();
   logic rise, fall, start, stop, addr_hit;
   logic [7:0] rdata;

   ////////////////////////////////////////////////////////////////////////
   // averager
   tmc_avg u_avg (
      .clock(clock),
      .rst_n(rst_n),
      .c(c.avg_end)
   );

   assign c.raw = raw_sample;
   assign c.raw_valid = raw_valid & s.run;
   assign c.clear = ~s.run;

   ////////////////////////////////////////////////////////////////////////
   // bus line events, from synchronised copies only
   assign rise = s.scl_s & ~s.scl_p;
   assign fall = ~s.scl_s & s.scl_p;
   assign start = s.scl_s & s.scl_p & s.sd_p & ~s.sd_s;
   assign stop = s.scl_s & s.scl_p & ~s.sd_p & s.sd_s;
   assign addr_hit = s.strap_ok && (s.sh[7:1] == s.dev_addr);

   // read mux; pointer value is whatever the host left, 00 after reset; unmapped values read 00
   always_comb begin
      case (s.ptr)
         REG_LTEMP: rdata = s.ltemp;
         REG_RTEMP: rdata = s.rtemp;
         REG_STAT: rdata = s.stat;
         REG_CFG: rdata = s.cfg;
         REG_LHI: rdata = s.lhi;
         REG_LLO: rdata = s.llo;
         REG_RHI: rdata = s.rhi;
         REG_RLO: rdata = s.rlo;
         REG_REV: rdata = {REV_PART, REV_STEP};
         default: rdata = RDATA_NONE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      n = s;
      n.scl_m = serial_clock_line;
      n.scl_s = s.scl_m;
      n.scl_p = s.scl_s;
      n.sd_m = serial_data_line_in;
      n.sd_s = s.sd_m;
      n.sd_p = s.sd_s;
      n.a0_m = addr_strap_zero;
      n.a0_s = s.a0_m;
      n.a1_m = addr_strap_one;
      n.a1_s = s.a1_m;
      n.op_m = remote_open;
      n.op_s = s.op_m;

      // straps caught once, after the synchronisers have filled
      if (!s.strap_ok) begin
         if (s.strap_cnt == STRAP_WAIT) begin
            n.strap_ok = 1'b1;
            n.dev_addr = tmc_addr(s.a0_s, s.a1_s);
         end else begin
            n.strap_cnt = 2'(s.strap_cnt + 2'h1);
         end
      end

      if (rise) begin
         n.sh = {s.sh[6:0], s.sd_s};
         n.cnt = 4'(s.cnt + 4'h1);
      end

      if (start) begin
         n.st = BS_ADDR;
         n.cnt = '0;
         n.sd_oe = 1'b0;
      end else if (stop) begin
         n.st = BS_IDLE;
         n.sd_oe = 1'b0;
      end else begin
         case (s.st)
            BS_IDLE: begin
               n.sd_oe = 1'b0;
            end
            BS_ADDR: begin
               if (fall && s.cnt == BITS_BYTE) begin
                  if (addr_hit) begin
                     n.rw = s.sh[0];
                     n.first = 1'b1;
                     n.sd_oe = 1'b1;
                     n.st = BS_ACK;
                  end else begin
                     n.st = BS_IDLE;
                  end
               end
            end
            BS_ACK: begin
               if (fall) begin
                  n.cnt = '0;
                  if (s.rw) begin
                     n.tx = rdata;
                     n.sd_oe = ~rdata[7];
                     n.st = BS_TX;
                  end else begin
                     n.sd_oe = 1'b0;
                     n.st = BS_RX;
                  end
               end
            end
            BS_RX: begin
               if (fall && s.cnt == BITS_BYTE) begin
                  n.sd_oe = 1'b1;
                  n.st = BS_ACK;
                  n.first = 1'b0;
                  if (s.first) begin
                     n.ptr = s.sh;
                  end else begin
                     case (s.ptr)
                        REG_CFG: n.cfg = s.sh & CFG_WMASK;
                        REG_LHI: n.lhi = s.sh;
                        REG_LLO: n.llo = s.sh;
                        REG_RHI: n.rhi = s.sh;
                        REG_RLO: n.rlo = s.sh;
                        default: n.cfg = s.cfg;
                     endcase
                  end
               end
            end
            BS_TX: begin
               if (fall) begin
                  if (s.cnt == BITS_BYTE) begin
                     n.sd_oe = 1'b0;
                     n.st = BS_MACK;
                  end else begin
                     n.tx = {s.tx[6:0], 1'b0};
                     n.sd_oe = ~s.tx[6];
                  end
               end
            end
            BS_MACK: begin
               if (fall && s.cnt == BITS_ACKED) begin
                  if (s.sh[0]) begin
                     n.st = BS_IDLE;
                  end else begin
                     n.cnt = '0;
                     n.tx = rdata;
                     n.sd_oe = ~rdata[7];
                     n.st = BS_TX;
                  end
               end
            end
            default: begin
               n.st = BS_IDLE;
               n.sd_oe = 1'b0;
            end
         endcase
      end

      // conversion results and limit compare
      n.run = ~s.cfg[CFG_STBY_BIT];
      if (c.avg_valid) begin
         if (s.sel) begin
            n.rtemp = c.avg;
            n.stat[ST_RHI] = $signed(c.avg) > $signed(s.rhi);
            n.stat[ST_RLO] = $signed(c.avg) < $signed(s.rlo);
         end else begin
            n.ltemp = c.avg;
            n.stat[ST_LHI] = $signed(c.avg) > $signed(s.lhi);
            n.stat[ST_LLO] = $signed(c.avg) < $signed(s.llo);
         end
         n.sel = ~s.sel;
      end
      n.stat[ST_OPEN] = s.op_s;
      n.alert_n = ~(|(n.stat & STAT_FLAGS)) | s.cfg[CFG_MASK_BIT];
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s <= CTL_RST;
      end else begin
         s <= n;
      end
   end

   assign serial_data_line_out_q = 1'b0;
   assign serial_data_line_oe_q = s.sd_oe;
   assign conv_run_q = s.run;
   assign sensor_sel_q = s.sel;
   assign alert_n_q = s.alert_n;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_alert_nor: assert property (
      (|(s.stat & STAT_FLAGS)) && !$past(s.cfg[CFG_MASK_BIT]) |-> !alert_n_q)
      else $error("alarm not asserted with a flag set");
   a_alert_mask: assert property (
      s.cfg[CFG_MASK_BIT] |=> alert_n_q)
      else $error("masked alarm still asserted");
   a_standby_stop: assert property (
      s.cfg[CFG_STBY_BIT] |=> !conv_run_q ##0 !c.raw_valid)
      else $error("converter running in standby");
   a_cfg_reserved: assert property (
      s.cfg[5:0] == 6'h00)
      else $error("reserved configuration bits set");
   a_chan_alt: assert property (
      c.avg_valid |=> sensor_sel_q != $past(sensor_sel_q))
      else $error("channel did not alternate");
   a_temp_src: assert property (
      $changed(s.ltemp) |-> $past(c.avg_valid && !s.sel)
         && s.ltemp == $past(c.avg))
      else $error("local value changed without a result");
   a_temp_range: assert property (
      $changed(s.rtemp) |-> !s.rtemp[7])
      else $error("remote value outside 0..127");
   a_limit_high: assert property (
      c.avg_valid && !s.sel && $signed(c.avg) > $signed(s.lhi)
         |=> s.stat[ST_LHI] ##1 !alert_n_q || $past(s.cfg[CFG_MASK_BIT]))
      else $error("local high flag missing");
   a_open_flag: assert property (
      s.op_s |=> s.stat[ST_OPEN])
      else $error("open sensor not flagged");
   a_strap_hold: assert property (
      s.strap_ok |=> s.strap_ok && $stable(s.dev_addr))
      else $error("slave address changed after capture");
   a_addr_ack: assert property (
      s.st == BS_ADDR && fall && s.cnt == BITS_BYTE && addr_hit
         |=> serial_data_line_oe_q ##0 s.st == BS_ACK)
      else $error("own address not acknowledged");
   a_ptr_load: assert property (
      s.st == BS_RX && fall && s.cnt == BITS_BYTE && s.first
         |=> s.ptr == $past(s.sh))
      else $error("pointer not loaded by first byte");
   a_rev_code: assert property (
      s.ptr == REG_REV |-> rdata[7:4] == REV_PART)
      else $error("revision part code wrong");

   c_result: cover property (c.avg_valid && s.sel);
   c_ptr_write: cover property (s.st == BS_RX && fall && s.first
      && s.cnt == BITS_BYTE);
   c_read: cover property (s.st == BS_MACK && fall && !s.sh[0]
      && s.cnt == BITS_ACKED);
   c_alarm: cover property ($fell(alert_n_q));

endmodule : tmc_ctl

// *** verif/tmc_host.sv ***
// partner: two-wire bus host driving the clock and an open-drain data line
module tmc_host (
   output logic serial_clock_line,
   output logic serial_data_line_low,
   input wire logic serial_data_line
);
   timeunit 1ns;
   timeprecision 100ps;

   // the clock stands high and the data line is released outside frames
   initial begin
      serial_clock_line = 1'b1;
      serial_data_line_low = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // bit level, 160 ns per bit
   task automatic bit_out(input logic b);
      serial_data_line_low = ~b;
      #40;
      serial_clock_line = 1'b1;
      #80;
      serial_clock_line = 1'b0;
      #40;
   endtask : bit_out

   task automatic bit_in(output logic b);
      serial_data_line_low = 1'b0;
      #40;
      serial_clock_line = 1'b1;
      #70;
      b = serial_data_line;
      #10;
      serial_clock_line = 1'b0;
      #40;
   endtask : bit_in

   task automatic start_cond();
      serial_data_line_low = 1'b0;
      serial_clock_line = 1'b1;
      #80;
      serial_data_line_low = 1'b1;
      #80;
      serial_clock_line = 1'b0;
      #40;
   endtask : start_cond

   task automatic stop_cond();
      serial_data_line_low = 1'b1;
      #40;
      serial_clock_line = 1'b1;
      #80;
      serial_data_line_low = 1'b0;
      #80;
   endtask : stop_cond

   ////////////////////////////////////////////////////////////////////////
   // byte level and register transfers
   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      bit_in(b);
      ack = ~b;
   endtask : byte_out

   task automatic byte_in(output logic [7:0] d, input logic more);
      logic b;
      d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         bit_in(b);
         d = {d[6:0], b};
      end
      // ack when another byte is wanted, nack on the last one
      bit_out(~more);
   endtask : byte_in

   task automatic write_reg(input logic [6:0] a, input logic [7:0] p,
                            input logic [7:0] d, input logic with_data,
                            output logic ok);
      logic k1;
      logic k2;
      logic k3;
      k2 = 1'b1;
      k3 = 1'b1;
      start_cond();
      byte_out({a, 1'b0}, k1);
      if (k1) begin
         byte_out(p, k2);
         if (with_data) begin
            byte_out(d, k3);
         end
      end
      stop_cond();
      ok = k1 & k2 & k3;
   endtask : write_reg

   task automatic read_reg(input logic [6:0] a, input logic [7:0] p,
                           output logic [7:0] d, output logic ok);
      logic k1;
      logic k2;
      write_reg(a, p, 8'h00, 1'b0, k1);
      start_cond();
      byte_out({a, 1'b1}, k2);
      byte_in(d, 1'b0);
      stop_cond();
      ok = k1 & k2;
   endtask : read_reg

   task automatic read_two(input logic [6:0] a, input logic [7:0] p,
                           output logic [7:0] d0, output logic [7:0] d1,
                           output logic ok);
      logic k1;
      logic k2;
      write_reg(a, p, 8'h00, 1'b0, k1);
      start_cond();
      byte_out({a, 1'b1}, k2);
      byte_in(d0, 1'b1);
      byte_in(d1, 1'b0);
      stop_cond();
      ok = k1 & k2;
   endtask : read_two

endmodule : tmc_host

// *** verif/tmc_ctl_test.sv ***
// bench: self-checking test of the temperature monitor control
`define CHECK_EQ(got, exp, msg) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         failures++; \
         $display("[FAIL] %0t %s", $time, msg); \
      end \
   end

module tmc_ctl_test;
   timeunit 1ns;
   timeprecision 100ps;
   import tmc_pkg::*;

   // about three times the expected run length
   localparam int LIMIT = 60000;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic scl, sd_low, sd_wire, sd_out, sd_oe;
   tmc_strap_t strap0 = STRAP_LOW;
   tmc_strap_t strap1 = STRAP_LOW;
   logic remote_open = 1'b0;
   logic [7:0] raw_sample = 8'h00;
   logic raw_valid = 1'b0;
   logic conv_run_q, sensor_sel_q, alert_n_q, ack;
   logic [7:0] rdata, rd2;
   logic [6:0] dev_a = 7'h18;
   logic [6:0] addr_tab [9] = '{7'h18, 7'h19, 7'h1a, 7'h29, 7'h2a, 7'h2b,
                                7'h4c, 7'h4d, 7'h4e};
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;

   // open-drain data line with pull-up
   assign sd_wire = ~sd_low & (~sd_oe | sd_out);

   tmc_host u_host (.serial_clock_line(scl), .serial_data_line_low(sd_low),
                    .serial_data_line(sd_wire));

   tmc_ctl u_dut (.clock(clock), .rst_n(rst_n), .serial_clock_line(scl),
                  .serial_data_line_in(sd_wire),
                  .serial_data_line_out_q(sd_out),
                  .serial_data_line_oe_q(sd_oe), .addr_strap_zero(strap0),
                  .addr_strap_one(strap1), .remote_open(remote_open),
                  .raw_sample(raw_sample), .raw_valid(raw_valid),
                  .conv_run_q(conv_run_q), .sensor_sel_q(sensor_sel_q),
                  .alert_n_q(alert_n_q));

   always #5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic end_sim();
      if (failures == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         $display("[FAIL] %0t run did not finish", $time);
         end_sim();
      end
   end

   task automatic do_reset(input tmc_strap_t a0, input tmc_strap_t a1);
      @(posedge clock);
      #1;
      rst_n = 1'b0;
      strap0 = a0;
      strap1 = a1;
      repeat (16) @(posedge clock);
      #1;
      rst_n = 1'b1;
      repeat (8) @(posedge clock);
      #1;
   endtask : do_reset

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      u_host.write_reg(dev_a, p, d, 1'b1, ack);
      `CHECK_EQ(ack, 1'b1, "write not acknowledged")
   endtask : wr

   task automatic rd(input logic [7:0] p, input logic [7:0] m,
                     input logic [7:0] e, input string msg);
      u_host.read_reg(dev_a, p, rdata, ack);
      `CHECK_EQ({ack, rdata & m}, {1'b1, e}, msg)
   endtask : rd

   // sixteen back-to-back samples base, base+1 .. base+15
   task automatic feed(input logic ch, input logic [7:0] base);
      `CHECK_EQ(sensor_sel_q, ch, "wrong channel selected")
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         #1;
         raw_sample = base + 8'(i);
         raw_valid = 1'b1;
      end
      @(posedge clock);
      #1;
      raw_valid = 1'b0;
      repeat (4) @(posedge clock);
      #1;
   endtask : feed

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset_values();
      `CHECK_EQ({conv_run_q, sensor_sel_q, alert_n_q}, 3'b101, "outputs")
      rd(REG_LTEMP, 8'hff, 8'h80, "local reset value");
      rd(REG_RTEMP, 8'hff, 8'h80, "remote reset value");
      rd(REG_CFG, 8'hff, 8'h00, "config reset value");
      rd(REG_REV, 8'hf0, {REV_PART, 4'h0}, "part code");
      rd(REG_STAT, 8'hff, 8'h00, "status after reset");
   endtask : t_reset_values

   task automatic t_standby();
      wr(REG_CFG, 8'hff);
      rd(REG_CFG, 8'hff, 8'hc0, "reserved config bits");
      `CHECK_EQ(conv_run_q, 1'b0, "standby not entered")
      feed(1'b0, 8'h28);
      `CHECK_EQ(sensor_sel_q, 1'b0, "converted in standby")
      rd(REG_LTEMP, 8'hff, 8'h80, "stored in standby");
      wr(REG_CFG, 8'h00);
      `CHECK_EQ(conv_run_q, 1'b1, "run not resumed")
   endtask : t_standby

   task automatic t_average();
      feed(1'b0, 8'h28);
      `CHECK_EQ(sensor_sel_q, 1'b1, "channel did not alternate")
      feed(1'b1, 8'hec);
      `CHECK_EQ(sensor_sel_q, 1'b0, "channel did not alternate")
      rd(REG_LTEMP, 8'hff, 8'h2f, "local average");
      rd(REG_RTEMP, 8'hff, 8'h00, "negative not clamped");
      u_host.read_two(dev_a, REG_LTEMP, rdata, rd2, ack);
      `CHECK_EQ({ack, rdata, rd2}, {1'b1, 8'h2f, 8'h2f}, "two-byte read")
   endtask : t_average

   task automatic t_limits();
      wr(REG_LHI, 8'h20);
      feed(1'b0, 8'h28);
      `CHECK_EQ(alert_n_q, 1'b0, "alarm not raised")
      rd(REG_STAT, 8'h7c, 8'h40, "local high flag");
      wr(REG_CFG, 8'h80);
      `CHECK_EQ(alert_n_q, 1'b1, "alarm not masked")
      wr(REG_CFG, 8'h00);
      wr(REG_LHI, 8'h7f);
      wr(REG_RHI, 8'h05);
      wr(REG_RLO, 8'h10);
      wr(REG_LLO, 8'h10);
      feed(1'b1, 8'h00);
      rd(REG_STAT, 8'h18, 8'h18, "remote flags");
      feed(1'b0, 8'h00);
      rd(REG_STAT, 8'h20, 8'h20, "local low flag");
      wr(REG_RHI, 8'h7f);
      wr(REG_RLO, 8'h00);
      wr(REG_LLO, 8'h00);
      feed(1'b1, 8'h00);
      feed(1'b0, 8'h00);
      rd(REG_STAT, 8'h7c, 8'h00, "flags not recomputed");
      `CHECK_EQ(alert_n_q, 1'b1, "alarm did not clear")
   endtask : t_limits

   task automatic t_open();
      @(posedge clock);
      #1;
      remote_open = 1'b1;
      repeat (6) @(posedge clock);
      #1;
      `CHECK_EQ(alert_n_q, 1'b0, "open sensor no alarm")
      rd(REG_STAT, 8'h04, 8'h04, "open sensor flag");
      @(posedge clock);
      #1;
      remote_open = 1'b0;
      repeat (6) @(posedge clock);
      #1;
      `CHECK_EQ(alert_n_q, 1'b1, "open flag stuck")
   endtask : t_open

   task automatic t_address();
      @(posedge clock);
      #1;
      strap0 = 2'h2;
      strap1 = 2'h2;
      rd(REG_CFG, 8'hff, 8'h00, "address moved");
      u_host.write_reg(7'h19, REG_CFG, 8'h00, 1'b0, ack);
      `CHECK_EQ(ack, 1'b0, "foreign address acknowledged")
      for (int k = 0; k < 9; k++) begin
         do_reset(tmc_strap_t'(k / 3), tmc_strap_t'(k % 3));
         dev_a = addr_tab[k];
         u_host.write_reg(dev_a, REG_CFG, 8'h00, 1'b0, ack);
         `CHECK_EQ(ack, 1'b1, "strap address not acknowledged")
      end
      do_reset(2'h3, 2'h3);
      dev_a = addr_tab[8];
      u_host.write_reg(dev_a, REG_CFG, 8'h00, 1'b0, ack);
      `CHECK_EQ(ack, 1'b1, "strap code 3 not high")
   endtask : t_address

   initial begin
      do_reset(STRAP_LOW, STRAP_LOW);
      t_reset_values();
      t_standby();
      t_average();
      t_limits();
      t_open();
      t_address();
      end_sim();
   end

endmodule : tmc_ctl_test
